// file: logic/fam_cfg.svh
// Constants of the receive frame alignment monitor.
// Assumes a line bit strobe synchronous to clk_sys at 100 MHz.
`ifndef FAM_CFG_SVH
`define FAM_CFG_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define FAM_FRAME_BITS      256
`define FAM_FAS_WORD        7'h1B
`define FAM_TS0_LAST_POS    9'h007
`define FAM_NFAS_LAST_POS   9'h107
`define FAM_B2_IDX          6
`define FAM_ERR_LIMIT       2'h3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define FAM_RAI_RST         1'b1
`define FAM_CLK_MHZ         100
`define FAM_QUIET_MS        20
`define FAM_QUIET_CYC       (`FAM_QUIET_MS * 1000 * `FAM_CLK_MHZ)

`endif

// file: logic/fam_frame_align.sv
// Receive frame alignment with remote alarm control for a 32 slot line.
// Assumes one received line bit per rx_bit_vld pulse, MSB of octet first.
// Functional notes
// - Match word in bits two to eight of slot zero; check bit two alternately.
// - One or two corrupted alignment words keep alignment and normal frames.
// - Three corrupted alignment words in a row lose alignment, start alarm.
// - Word, bit two one, then corrupted word does not regain; alarm stays.
// - Bit two zero once or twice in a row keeps alignment.
// - Bit two zero three times may lose alignment; option parameter decides.
// - Lock on an imitation word without multiframe alignment is dropped.
// - After realignment no alarm for 20 ms while correct frames arrive.
`timescale 1ns/1ns
`include "fam_cfg.svh"

module fam_frame_align #(
    parameter bit          LOSE_ON_B2 = 1'b0,
    parameter int unsigned QUIET_CYC  = `FAM_QUIET_CYC
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic arst_n,
    // Received line
    input  wire logic rx_bit,
    input  wire logic rx_bit_vld,
    input  wire logic mfa_lost,
    // Status and transmit alarm
    output logic      frame_aligned,
    output logic      tx_rai_bit,
    output logic      fas_error
);
    import fam_pkg::*;

    fam_regs_t cur_ff;
    fam_regs_t nxt_cur;
    logic [6:0] sr_new;
    logic       fas_ok;
    logic       b2_val;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.fas_bad = 1'b0;
        sr_new = {cur_ff.sr[5:0], rx_bit};
        fas_ok = (sr_new == `FAM_FAS_WORD);
        b2_val = sr_new[`FAM_B2_IDX];
        if (rx_bit_vld) begin
            nxt_cur.sr  = sr_new;
            nxt_cur.pos = (cur_ff.pos == 9'(2 * `FAM_FRAME_BITS - 1)) ?
                          9'h000 : cur_ff.pos + 9'h001;
            case (cur_ff.state)
                FAM_HUNT: begin
                    if (fas_ok) begin
                        nxt_cur.pos   = `FAM_TS0_LAST_POS + 9'h001;
                        nxt_cur.state = FAM_CONF_B2;
                    end
                end
                FAM_CONF_B2: begin
                    if (cur_ff.pos == `FAM_NFAS_LAST_POS) begin
                        // A zero in bit two does not count toward regain.
                        nxt_cur.state = b2_val ? FAM_CONF_FAS
                                               : FAM_HUNT;
                    end
                end
                FAM_CONF_FAS: begin
                    if (cur_ff.pos == `FAM_TS0_LAST_POS) begin
                        if (fas_ok) begin
                            nxt_cur.state   = FAM_SYNC;
                            nxt_cur.rai     = 1'b0;
                            nxt_cur.aligned = 1'b1;
                            nxt_cur.fas_err = 2'h0;
                            nxt_cur.b2_zero = 2'h0;
                        end else begin
                            nxt_cur.state = FAM_HUNT;
                        end
                    end
                end
                FAM_SYNC: begin
                    if (cur_ff.pos == `FAM_TS0_LAST_POS) begin
                        nxt_cur.fas_bad = !fas_ok;
                        // A correct word clears the error run.
                        nxt_cur.fas_err = fas_ok ? 2'h0
                                        : cur_ff.fas_err + 2'h1;
                        if (!fas_ok && cur_ff.fas_err
                            == `FAM_ERR_LIMIT - 2'h1) begin
                            nxt_cur.state = FAM_HUNT;
                        end
                    end
                    if (cur_ff.pos == `FAM_NFAS_LAST_POS) begin
                        nxt_cur.b2_zero = b2_val ? 2'h0
                                        : cur_ff.b2_zero + 2'h1;
                        if (!b2_val && LOSE_ON_B2 && cur_ff.b2_zero
                            == `FAM_ERR_LIMIT - 2'h1) begin
                            nxt_cur.state = FAM_HUNT;
                        end
                        if (!b2_val && cur_ff.b2_zero
                            == `FAM_ERR_LIMIT - 2'h1) begin
                            nxt_cur.b2_zero = 2'h0;
                        end
                    end
                end
                default: nxt_cur.state = FAM_HUNT;
            endcase
        end
        // A lock without multiframe alignment is an imitation word.
        if (cur_ff.state == FAM_SYNC && mfa_lost) begin
            nxt_cur.state = FAM_HUNT;
        end
        // Loss only from the steps above, so correct frames keep quiet.
        if (cur_ff.state == FAM_SYNC && nxt_cur.state == FAM_HUNT) begin
            nxt_cur.rai     = 1'b1;
            nxt_cur.aligned = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff <= '{state: FAM_HUNT, pos: 9'h000, sr: 7'h00,
                        fas_err: 2'h0, b2_zero: 2'h0,
                        rai: `FAM_RAI_RST, aligned: 1'b0,
                        fas_bad: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign frame_aligned = cur_ff.aligned;
    assign tx_rai_bit    = cur_ff.rai;
    assign fas_error     = cur_ff.fas_bad;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [31:0] quiet_cnt;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            quiet_cnt <= 32'h0;
        end else if (!cur_ff.aligned || cur_ff.fas_bad) begin
            quiet_cnt <= 32'h0;
        end else if (quiet_cnt < QUIET_CYC) begin
            quiet_cnt <= quiet_cnt + 32'h1;
        end
    end

    sequence s_sync_ts0;
        cur_ff.state == FAM_SYNC && rx_bit_vld &&
        cur_ff.pos == `FAM_TS0_LAST_POS;
    endsequence

    sequence s_conf_ts0;
        cur_ff.state == FAM_CONF_FAS && rx_bit_vld &&
        cur_ff.pos == `FAM_TS0_LAST_POS;
    endsequence

    property p_word_match;
        @(posedge clk_sys) disable iff (!arst_n)
        s_sync_ts0 |=> (fas_error == !$past(fas_ok));
    endproperty
    a_word_match: assert property (p_word_match)
        else $error("Word check disagrees with received bits.");

    property p_keep_two;
        @(posedge clk_sys) disable iff (!arst_n)
        s_sync_ts0 ##0 ((cur_ff.fas_err < 2'h2 || fas_ok) && !mfa_lost)
            |=> frame_aligned;
    endproperty
    a_keep_two: assert property (p_keep_two)
        else $error("Alignment lost before three bad words.");

    property p_lose_three;
        @(posedge clk_sys) disable iff (!arst_n)
        s_sync_ts0 ##0 (cur_ff.fas_err == 2'h2 && !fas_ok)
            |=> !frame_aligned && tx_rai_bit;
    endproperty
    a_lose_three: assert property (p_lose_three)
        else $error("Three bad words did not raise the alarm.");

    property p_regain;
        @(posedge clk_sys) disable iff (!arst_n)
        s_conf_ts0 ##0 fas_ok |=> frame_aligned && !tx_rai_bit;
    endproperty
    a_regain: assert property (p_regain)
        else $error("Confirmed word did not restore alignment.");

    property p_no_regain_bad;
        @(posedge clk_sys) disable iff (!arst_n)
        s_conf_ts0 ##0 !fas_ok |=> !frame_aligned && tx_rai_bit;
    endproperty
    a_no_regain_bad: assert property (p_no_regain_bad)
        else $error("Alignment regained on a bad word.");

    property p_b2_zero_hunt;
        @(posedge clk_sys) disable iff (!arst_n)
        cur_ff.state == FAM_CONF_B2 && rx_bit_vld &&
        cur_ff.pos == `FAM_NFAS_LAST_POS && !b2_val
            |=> cur_ff.state == FAM_HUNT;
    endproperty
    a_b2_zero_hunt: assert property (p_b2_zero_hunt)
        else $error("Bit two zero counted toward regain.");

    property p_b2_keep;
        @(posedge clk_sys) disable iff (!arst_n)
        cur_ff.state == FAM_SYNC && !mfa_lost && !LOSE_ON_B2 &&
        !(rx_bit_vld && cur_ff.pos == `FAM_TS0_LAST_POS)
            |=> frame_aligned;
    endproperty
    a_b2_keep: assert property (p_b2_keep)
        else $error("Bit two zeros broke alignment.");

    property p_mfa_drop;
        @(posedge clk_sys) disable iff (!arst_n)
        frame_aligned && mfa_lost |=> tx_rai_bit && !frame_aligned;
    endproperty
    a_mfa_drop: assert property (p_mfa_drop)
        else $error("Imitation lock not dropped.");

    property p_quiet;
        @(posedge clk_sys) disable iff (!arst_n)
        frame_aligned && quiet_cnt < QUIET_CYC && !mfa_lost &&
        !(cur_ff.state == FAM_SYNC && rx_bit_vld &&
          cur_ff.pos == `FAM_TS0_LAST_POS && !fas_ok) |=> !tx_rai_bit;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("Alarm raised while correct frames arrive.");

    property p_alarm_bit;
        @(posedge clk_sys) disable iff (!arst_n)
        tx_rai_bit == !frame_aligned;
    endproperty
    a_alarm_bit: assert property (p_alarm_bit)
        else $error("Alarm bit does not follow alignment.");

endmodule // fam_frame_align

// file: logic/fam_pkg.sv
// Types of the receive frame alignment monitor.
// Assumes fam_cfg.svh holds all numeric constants.
package fam_pkg;

    typedef enum logic [1:0] {
        FAM_HUNT,
        FAM_CONF_B2,
        FAM_CONF_FAS,
        FAM_SYNC
    } fam_state_t;

    typedef struct packed {
        fam_state_t  state;
        logic [8:0]  pos;
        logic [6:0]  sr;
        logic [1:0]  fas_err;
        logic [1:0]  b2_zero;
        logic        rai;
        logic        aligned;
        logic        fas_bad;
    } fam_regs_t;

endpackage

// file: verification/fam_line_model.sv
// Line partner model: sends double frames of received bits to the monitor.
// Assumes the bench calls send_pair from one process; bits move at negedge.
`timescale 1ns/1ns

module fam_line_model (
    // Clock
    input  wire logic clk_sys,
    // Line towards the monitor
    output logic      rx_bit,
    output logic      rx_bit_vld
);
    // ----------------------------------------------------------------
    // Frame generation
    // ----------------------------------------------------------------
    initial begin
        rx_bit     = 1'b0;
        rx_bit_vld = 1'b0;
    end

    // Payload never holds two zeros in a row, so it never forms a word.
    function automatic logic [7:0] pay_octet();
        return 8'($urandom() | 32'hAA);
    endfunction

    task automatic send_bit(input logic b);
        int gap;
        gap = $urandom_range(1, 0);
        @(negedge clk_sys);
        rx_bit     = b;
        rx_bit_vld = 1'b1;
        @(negedge clk_sys);
        rx_bit_vld = 1'b0;
        rx_bit     = ~b;
        repeat (gap) @(negedge clk_sys);
    endtask

    task automatic send_octet(input logic [7:0] o);
        for (int i = 7; i >= 0; i--) begin
            send_bit(o[i]);
        end
    endtask

    // Non-word frame, then word frame; a bad word flips one of bits 2..6.
    task automatic send_pair(input logic b2, input logic fas_ok);
        logic [7:0] word;
        word = 8'h9B;
        if (!fas_ok) begin
            word = word ^ (8'h40 >> $urandom_range(4, 0));
        end
        send_octet({1'b1, b2, 1'b0, 5'h1F});
        repeat (31) send_octet(pay_octet());
        send_octet(word);
        repeat (31) send_octet(pay_octet());
    endtask

    // Imitation pair: false bit two one and false word in slot 31.
    task automatic send_imit_pair(input logic fas_ok);
        logic [7:0] word;
        word = 8'h9B;
        if (!fas_ok) begin
            word = word ^ (8'h40 >> $urandom_range(4, 0));
        end
        send_octet(8'hDF);
        repeat (30) send_octet(pay_octet());
        send_octet(8'hDF);
        send_octet(word);
        repeat (30) send_octet(pay_octet());
        send_octet(8'h9B);
    endtask
endmodule // fam_line_model

// file: verification/tb.sv
// Self-checking bench of the receive frame alignment monitor.
// Assumes fam_line_model drives the line; the bench drives mfa_lost.
`timescale 1ns/1ns

module tb;
    logic clk_sys;
    logic arst_n;
    logic rx_bit;
    logic rx_bit_vld;
    logic mfa_lost;
    logic frame_aligned;
    logic tx_rai_bit;
    logic fas_error;
    int   miscompares;
    int   n_tests;
    int   n_err = 0;
    int   exp_err;
    int   nb;
    logic watch_rai;
    logic rai_seen;
    logic lose_aligned;
    logic lose_rai;

    fam_frame_align #(
        .LOSE_ON_B2 (1'b0),
        .QUIET_CYC  (2000)
    ) u_fam_frame_align (
        .clk_sys       (clk_sys),
        .arst_n        (arst_n),
        .rx_bit        (rx_bit),
        .rx_bit_vld    (rx_bit_vld),
        .mfa_lost      (mfa_lost),
        .frame_aligned (frame_aligned),
        .tx_rai_bit    (tx_rai_bit),
        .fas_error     (fas_error)
    );

    fam_line_model u_fam_line_model (
        .clk_sys    (clk_sys),
        .rx_bit     (rx_bit),
        .rx_bit_vld (rx_bit_vld)
    );

    // Second monitor takes the option that loses lock on bit two zeros.
    if (1'b1) begin : g_lose
        fam_frame_align #(
            .LOSE_ON_B2 (1'b1),
            .QUIET_CYC  (2000)
        ) u_fam_frame_align (
            .clk_sys       (clk_sys),
            .arst_n        (arst_n),
            .rx_bit        (rx_bit),
            .rx_bit_vld    (rx_bit_vld),
            .mfa_lost      (mfa_lost),
            .frame_aligned (lose_aligned),
            .tx_rai_bit    (lose_rai),
            .fas_error     ()
        );
    end

    // ----------------------------------------------------------------
    // Clock, monitors and helpers
    // ----------------------------------------------------------------
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (fas_error === 1'b1) begin
            n_err <= n_err + 1;
        end
        if (watch_rai !== 1'b1) begin
            rai_seen <= 1'b0;
        end else if (tx_rai_bit !== 1'b0) begin
            rai_seen <= 1'b1;
        end
    end

    function automatic logic [1:0] exp_status(input logic al);
        return {al, ~al};
    endfunction

    task automatic check(input string name, input logic [15:0] got,
                         input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic status(input string name, input logic al);
        check(name, {14'h0000, frame_aligned, tx_rai_bit},
              {14'h0000, exp_status(al)});
        $display("test %s done", name);
    endtask

    task automatic pairs(input int n, input logic b2, input logic ok);
        repeat (n) u_fam_line_model.send_pair(b2, ok);
    endtask

    task automatic imit(input int n, input logic ok);
        repeat (n) u_fam_line_model.send_imit_pair(ok);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #950000;
        miscompares++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        arst_n      = 1'b0;
        mfa_lost    = 1'b0;
        watch_rai   = 1'b0;
        miscompares = 0;
        n_tests     = 0;
        void'($urandom(32'h9994));
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        status("reset", 1'b0);
        pairs(3, 1'b1, 1'b1);
        status("sync", 1'b1);
        exp_err = n_err;
        for (int i = 0; i < 6; i++) begin
            nb = $urandom_range(2, 0);
            exp_err += nb;
            pairs(nb, 1'b1, 1'b0);
            pairs(1, 1'b1, 1'b1);
            status("few_bad", 1'b1);
        end
        pairs(3, 1'b1, 1'b0);
        status("three_bad", 1'b0);
        check("fas_err_cnt", 16'(n_err), 16'(exp_err + 3));
        repeat (2) begin
            pairs(1, 1'b1, 1'b1);
            pairs(1, 1'b1, 1'b0);
        end
        status("word_b2_bad", 1'b0);
        pairs(3, 1'b0, 1'b1);
        status("b2_zero_hunt", 1'b0);
        pairs(3, 1'b1, 1'b1);
        status("resync", 1'b1);
        pairs(1, 1'b0, 1'b1);
        pairs(1, 1'b1, 1'b1);
        status("b2_zero_once", 1'b1);
        pairs(2, 1'b0, 1'b1);
        pairs(1, 1'b1, 1'b1);
        status("b2_zero_twice", 1'b1);
        pairs(3, 1'b0, 1'b1);
        status("b2_zero_thrice", 1'b1);
        check("b2_lose", {14'h0000, lose_aligned, lose_rai},
              {14'h0000, exp_status(1'b0)});
        imit(1, 1'b1);
        status("imit_keep", 1'b1);
        imit(3, 1'b0);
        status("imit_loss", 1'b0);
        imit(3, 1'b0);
        status("imit_lock", 1'b1);
        @(negedge clk_sys);
        mfa_lost = 1'b1;
        @(negedge clk_sys);
        mfa_lost = 1'b0;
        status("mfa_drop", 1'b0);
        pairs(3, 1'b1, 1'b1);
        status("realign", 1'b1);
        watch_rai = 1'b1;
        pairs(2, 1'b1, 1'b1);
        watch_rai = 1'b0;
        check("rai_quiet", {15'h0000, rai_seen}, 16'h0000);
        report_and_stop();
    end
endmodule // tb
